/* File: src/dprf_top.sv */
`timescale 1ns/1ps
module dprf_top (
    // clock and reset
    input  wire logic                clk,
    input  wire logic                rst_n,
    // mode control
    input  wire logic                simd_en,
    input  wire logic                alt_wr,
    input  wire logic                alt_val,
    output logic                     alt_sel_q,
    // data memory data bus
    input  wire logic                dm_req,
    input  wire logic                dm_wr,
    input  wire logic                dm_elem,
    input  wire logic                dm_lw,
    input  wire logic                dm_w32,
    input  wire dprf_pkg::dprf_idx_t dm_idx,
    input  wire dprf_pkg::dprf_bus_t dm_wdata_x,
    input  wire dprf_pkg::dprf_bus_t dm_wdata_y,
    output logic                     dm_rvalid,
    output dprf_pkg::dprf_bus_t      dm_rdata_x,
    output dprf_pkg::dprf_bus_t      dm_rdata_y,
    // program memory data bus
    input  wire logic                pm_req,
    input  wire logic                pm_wr,
    input  wire logic                pm_elem,
    input  wire logic                pm_lw,
    input  wire logic                pm_w32,
    input  wire dprf_pkg::dprf_idx_t pm_idx,
    input  wire dprf_pkg::dprf_bus_t pm_wdata_x,
    input  wire dprf_pkg::dprf_bus_t pm_wdata_y,
    output logic                     pm_rvalid,
    output dprf_pkg::dprf_bus_t      pm_rdata_x,
    output dprf_pkg::dprf_bus_t      pm_rdata_y,
    // bus exchange register
    input  wire logic                px_lo_wr,
    input  wire logic                px_hi_wr,
    input  wire logic [31:0]         px_wdata,
    input  wire logic                px_to_reg,
    input  wire dprf_pkg::dprf_idx_t px_idx,
    output dprf_pkg::dprf_bus_t      px_q,
    // alu results
    input  wire logic                alu_wr,
    input  wire dprf_pkg::dprf_idx_t alu_idx,
    input  wire dprf_pkg::dprf_reg_t alu_res_x,
    input  wire dprf_pkg::dprf_reg_t alu_res_y,
    // multiplier results
    input  wire logic                mul_wr,
    input  wire dprf_pkg::dprf_idx_t mul_idx,
    input  wire dprf_pkg::dprf_reg_t mul_res_x,
    input  wire dprf_pkg::dprf_reg_t mul_res_y,
    // shifter results
    input  wire logic                shf_wr,
    input  wire dprf_pkg::dprf_idx_t shf_idx,
    input  wire dprf_pkg::dprf_reg_t shf_res_x,
    input  wire dprf_pkg::dprf_reg_t shf_res_y
);
    logic                rst_meta_r;
    logic                rst_sync_r;
    logic                alt_r;
    dprf_pkg::dprf_bus_t px_r;
    logic                dm_rvalid_r;
    logic                pm_rvalid_r;
    dprf_pkg::dprf_bus_t dm_rx_r;
    dprf_pkg::dprf_bus_t dm_ry_r;
    dprf_pkg::dprf_bus_t pm_rx_r;
    dprf_pkg::dprf_bus_t pm_ry_r;
    dprf_pkg::dprf_reg_t rdat [dprf_pkg::NPE][dprf_pkg::NRD];
    dprf_pkg::dprf_idx_t dm_a;
    dprf_pkg::dprf_idx_t dm_b;
    dprf_pkg::dprf_idx_t pm_a;
    dprf_pkg::dprf_idx_t pm_b;
    logic                dm_rd;
    logic                pm_rd;

    dprf_bank_if bif [dprf_pkg::NPE] ();

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_r <= 1'b0;
            rst_sync_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_sync_r <= rst_meta_r;
        end
    end

    // set select is registered, so a switch shows one cycle after the write
    always_ff @(posedge clk or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            alt_r <= dprf_pkg::ALT_RST;
        end else if (alt_wr) begin
            alt_r <= alt_val;
        end
    end

    // two halves written independently
    always_ff @(posedge clk or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            px_r <= dprf_pkg::PX_RST;
        end else begin
            if (px_lo_wr) begin
                px_r[dprf_pkg::WW-1:0] <= px_wdata;
            end
            if (px_hi_wr) begin
                px_r[dprf_pkg::BW-1:dprf_pkg::WW] <= px_wdata;
            end
        end
    end

    // long word: even register and its odd neighbour
    always_comb begin
        dm_a  = dm_lw ? {dm_idx[3:1], 1'b0} : dm_idx;
        dm_b  = {dm_idx[3:1], 1'b1};
        pm_a  = pm_lw ? {pm_idx[3:1], 1'b0} : pm_idx;
        pm_b  = {pm_idx[3:1], 1'b1};
        dm_rd = dm_req && !dm_wr;
        pm_rd = pm_req && !pm_wr;
    end

    for (genvar e = 0; e < dprf_pkg::NPE; e++) begin : g_pe
        logic                dm_on;
        logic                pm_on;
        logic                cmp_on;
        logic [7:0]          en;
        dprf_pkg::dprf_idx_t ix [dprf_pkg::NSRC];
        dprf_pkg::dprf_reg_t dt [dprf_pkg::NSRC];
        dprf_pkg::dprf_bus_t dmw;
        dprf_pkg::dprf_bus_t pmw;

        always_comb begin
            // second file follows a first-element name in dual mode, or is named itself
            dm_on  = (e == 0) ? !dm_elem : (dm_elem || simd_en);
            pm_on  = (e == 0) ? !pm_elem : (pm_elem || simd_en);
            cmp_on = (e == 0) || simd_en;
            dmw    = (e == 0) ? dm_wdata_x : dm_wdata_y;
            pmw    = (e == 0) ? pm_wdata_x : pm_wdata_y;
            // precedence is fixed by the source slot; x and y units hit separate files
            en[dprf_pkg::SRC_DM_A] = dm_req && dm_wr && dm_on;
            ix[dprf_pkg::SRC_DM_A] = dm_a;
            dt[dprf_pkg::SRC_DM_A] = dprf_pkg::dprf_unpack(dm_lw, dm_w32, 1'b0, dmw);
            en[dprf_pkg::SRC_DM_B] = dm_req && dm_wr && dm_on && dm_lw;
            ix[dprf_pkg::SRC_DM_B] = dm_b;
            dt[dprf_pkg::SRC_DM_B] = dprf_pkg::dprf_unpack(1'b1, 1'b0, 1'b1, dmw);
            en[dprf_pkg::SRC_PX]   = px_to_reg && (e == 0);
            ix[dprf_pkg::SRC_PX]   = px_idx;
            dt[dprf_pkg::SRC_PX]   = px_r[dprf_pkg::BW-1:dprf_pkg::PX_MOVE_LSB];
            en[dprf_pkg::SRC_PM_A] = pm_req && pm_wr && pm_on;
            ix[dprf_pkg::SRC_PM_A] = pm_a;
            dt[dprf_pkg::SRC_PM_A] = dprf_pkg::dprf_unpack(pm_lw, pm_w32, 1'b0, pmw);
            en[dprf_pkg::SRC_PM_B] = pm_req && pm_wr && pm_on && pm_lw;
            ix[dprf_pkg::SRC_PM_B] = pm_b;
            dt[dprf_pkg::SRC_PM_B] = dprf_pkg::dprf_unpack(1'b1, 1'b0, 1'b1, pmw);
            en[dprf_pkg::SRC_ALU]  = alu_wr && cmp_on;
            ix[dprf_pkg::SRC_ALU]  = alu_idx;
            dt[dprf_pkg::SRC_ALU]  = (e == 0) ? alu_res_x : alu_res_y;
            en[dprf_pkg::SRC_MUL]  = mul_wr && cmp_on;
            ix[dprf_pkg::SRC_MUL]  = mul_idx;
            dt[dprf_pkg::SRC_MUL]  = (e == 0) ? mul_res_x : mul_res_y;
            en[dprf_pkg::SRC_SHF]  = shf_wr && cmp_on;
            ix[dprf_pkg::SRC_SHF]  = shf_idx;
            dt[dprf_pkg::SRC_SHF]  = (e == 0) ? shf_res_x : shf_res_y;
        end

        assign bif[e].alt     = alt_r;
        assign bif[e].wr_en   = en;
        assign bif[e].wr_idx  = ix;
        assign bif[e].wr_data = dt;
        assign bif[e].rd_idx[dprf_pkg::RD_DM_A] = dm_a;
        assign bif[e].rd_idx[dprf_pkg::RD_DM_B] = dm_b;
        assign bif[e].rd_idx[dprf_pkg::RD_PM_A] = pm_a;
        assign bif[e].rd_idx[dprf_pkg::RD_PM_B] = pm_b;
        assign rdat[e] = bif[e].rd_data;

        dprf_bank u_bank (
            .clk   (clk),
            .rst_n (rst_sync_r),
            .bif   (bif[e])
        );
    end

    // reads answer one cycle later on the bus that asked; both buses in parallel
    always_ff @(posedge clk or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            dm_rvalid_r <= 1'b0;
            pm_rvalid_r <= 1'b0;
            dm_rx_r     <= '0;
            dm_ry_r     <= '0;
            pm_rx_r     <= '0;
            pm_ry_r     <= '0;
        end else begin
            dm_rvalid_r <= dm_rd;
            pm_rvalid_r <= pm_rd;
            dm_rx_r <= (dm_rd && !dm_elem) ? dprf_pkg::dprf_pack(dm_lw, dm_w32,
                       rdat[0][dprf_pkg::RD_DM_A], rdat[0][dprf_pkg::RD_DM_B]) : '0;
            dm_ry_r <= (dm_rd && g_pe[1].dm_on) ? dprf_pkg::dprf_pack(dm_lw, dm_w32,
                       rdat[1][dprf_pkg::RD_DM_A], rdat[1][dprf_pkg::RD_DM_B]) : '0;
            pm_rx_r <= (pm_rd && !pm_elem) ? dprf_pkg::dprf_pack(pm_lw, pm_w32,
                       rdat[0][dprf_pkg::RD_PM_A], rdat[0][dprf_pkg::RD_PM_B]) : '0;
            pm_ry_r <= (pm_rd && g_pe[1].pm_on) ? dprf_pkg::dprf_pack(pm_lw, pm_w32,
                       rdat[1][dprf_pkg::RD_PM_A], rdat[1][dprf_pkg::RD_PM_B]) : '0;
        end
    end

    assign alt_sel_q  = alt_r;
    assign px_q       = px_r;
    assign dm_rvalid  = dm_rvalid_r;
    assign pm_rvalid  = pm_rvalid_r;
    assign dm_rdata_x = dm_rx_r;
    assign dm_rdata_y = dm_ry_r;
    assign pm_rdata_x = pm_rx_r;
    assign pm_rdata_y = pm_ry_r;

    property p_w32_read;
        @(posedge clk) disable iff (!rst_sync_r)
        (dm_rd && dm_w32 && !dm_lw) |=> (dm_rdata_x[63:32] == 32'h0000_0000);
    endproperty
    a_w32_read: assert property (p_w32_read) else $error("32-bit read not in low word");

    property p_alt_switch;
        @(posedge clk) disable iff (!rst_sync_r)
        (alt_wr && (alt_val != alt_sel_q)) |->
            ##1 (alt_sel_q == $past(alt_val)) ##1 ($stable(alt_sel_q) || $past(alt_wr));
    endproperty
    a_alt_switch: assert property (p_alt_switch) else $error("set switch latency wrong");

    property p_y_compute;
        @(posedge clk) disable iff (!rst_sync_r)
        !simd_en |-> (g_pe[1].en[7:5] == 3'b000);
    endproperty
    a_y_compute: assert property (p_y_compute) else $error("second element ran alone");

    property p_y_move;
        @(posedge clk) disable iff (!rst_sync_r)
        (dm_req && dm_wr && dm_elem) |-> g_pe[1].en[0] && !g_pe[0].en[0];
    endproperty
    a_y_move: assert property (p_y_move) else $error("move to second element dropped");

    property p_compl;
        @(posedge clk) disable iff (!rst_sync_r)
        (simd_en && pm_req && pm_wr && !pm_elem) |->
            g_pe[0].en[3] && g_pe[1].en[3] && (g_pe[1].ix[3] == g_pe[0].ix[3]);
    endproperty
    a_compl: assert property (p_compl) else $error("complementary register not written");

    property p_pair;
        @(posedge clk) disable iff (!rst_sync_r)
        (dm_req && dm_wr && dm_lw && !dm_elem) |->
            g_pe[0].en[1] && !g_pe[0].ix[0][0] && (g_pe[0].ix[1] == {g_pe[0].ix[0][3:1], 1'b1});
    endproperty
    a_pair: assert property (p_pair) else $error("long-word pair malformed");

    property p_px_halves;
        @(posedge clk) disable iff (!rst_sync_r)
        (px_lo_wr && !px_hi_wr) |=>
            (px_q[31:0] == $past(px_wdata)) && (px_q[63:32] == $past(px_q[63:32]));
    endproperty
    a_px_halves: assert property (p_px_halves) else $error("exchange halves coupled");

    property p_dual_read;
        @(posedge clk) disable iff (!rst_sync_r)
        (dm_rd && pm_rd) |=> dm_rvalid && pm_rvalid;
    endproperty
    a_dual_read: assert property (p_dual_read) else $error("parallel reads not answered");

    property p_same_instr;
        @(posedge clk) disable iff (!rst_sync_r)
        (simd_en && alu_wr) |-> g_pe[0].en[5] && g_pe[1].en[5] && (g_pe[0].ix[5] == g_pe[1].ix[5]);
    endproperty
    a_same_instr: assert property (p_same_instr) else $error("elements diverged");

    property p_px_high;
        @(posedge clk) disable iff (!rst_sync_r)
        (px_hi_wr && !px_lo_wr) |=>
            (px_q[63:32] == $past(px_wdata)) && (px_q[31:0] == $past(px_q[31:0]));
    endproperty
    a_px_high: assert property (p_px_high) else $error("exchange high half coupled");

    property p_alt_hold;
        @(posedge clk) disable iff (!rst_sync_r)
        !alt_wr |=> $stable(alt_sel_q);
    endproperty
    a_alt_hold: assert property (p_alt_hold) else $error("set select moved unasked");

    property p_rd_idle;
        @(posedge clk) disable iff (!rst_sync_r)
        !dm_rd |=> !dm_rvalid && (dm_rdata_x == '0) && (dm_rdata_y == '0);
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("data bus answer without read");

    property p_prec;
        @(posedge clk) disable iff (!rst_sync_r)
        (g_pe[0].en[0] && g_pe[0].en[5] && (dm_a == alu_idx) && !alt_wr) |=>
            (g_pe[0].u_bank.mem_r[alt_r][$past(dm_a)] == $past(g_pe[0].dt[0]));
    endproperty
    a_prec: assert property (p_prec) else $error("lower precedence write won");

    property p_w32_write;
        @(posedge clk) disable iff (!rst_sync_r)
        (dm_req && dm_wr && dm_w32 && !dm_lw && !dm_elem && !alt_wr) |=>
            (g_pe[0].u_bank.mem_r[alt_r][$past(dm_idx)] == {$past(dm_wdata_x[31:0]), 8'h00});
    endproperty
    a_w32_write: assert property (p_w32_write) else $error("32-bit write misplaced");
endmodule

/* File: pkg/dprf_pkg.sv */
// Overview of operation
// - every data register location in both files holds a full 40-bit value.
// - 32-bit transfers sit in the upper bits; low eight ignored on read, cleared on write.
// - each element file has sixteen primary and sixteen alternate locations.
// - one program bus and one data bus access per element in one cycle.
// - each memory data bus carries at most 64 valid bits per element per access, 128 in dual element mode.
// - program memory moves use the program bus, data memory moves the data bus.
// - long-word moves pair each even register with the next odd register.
// - in dual element mode, naming a first element register implies the same number in the second file; exchange register moves write the first file only.
// - moves into second element registers also complete in single element mode.
// - the second element writes computed results only in dual element mode.
// - both elements run the same compute instruction on their own registers.
// - several same-cycle writes to one location keep only the highest precedence.
// - precedence: first_address_generator/ureg, second_address_generator, alu x, alu y, mul x, mul y, shf x, shf y.
// - the bus exchange register is 64 bits, two independent 32-bit halves.
// - primary/alternate switch takes effect one cycle after the mode write.
package dprf_pkg;
    localparam int DW   = 40;
    localparam int BW   = 64;
    localparam int WW   = 32;
    localparam int PAD  = 8;
    localparam int NREG = 16;
    localparam int NSET = 2;
    localparam int NSRC = 8;
    localparam int NRD  = 4;
    localparam int NPE  = 2;
    // write sources, index 0 has the highest precedence
    localparam int SRC_DM_A = 0;
    localparam int SRC_DM_B = 1;
    localparam int SRC_PX   = 2;
    localparam int SRC_PM_A = 3;
    localparam int SRC_PM_B = 4;
    localparam int SRC_ALU  = 5;
    localparam int SRC_MUL  = 6;
    localparam int SRC_SHF  = 7;
    // read ports
    localparam int RD_DM_A = 0;
    localparam int RD_DM_B = 1;
    localparam int RD_PM_A = 2;
    localparam int RD_PM_B = 3;
    // upper 40 bits of the exchange register move to a data register
    localparam int PX_MOVE_LSB = 24;
    localparam logic [DW-1:0] REG_RST = 40'h00_0000_0000;
    localparam logic [BW-1:0] PX_RST  = 64'h0000_0000_0000_0000;
    localparam logic          ALT_RST = 1'b0;

    typedef logic [DW-1:0] dprf_reg_t;
    typedef logic [3:0]    dprf_idx_t;
    typedef logic [BW-1:0] dprf_bus_t;

    // register(s) to bus: long word puts the even register low, odd high
    function automatic dprf_bus_t dprf_pack(input logic lw, input logic w32,
                                            input dprf_reg_t a, input dprf_reg_t b);
        if (lw) begin
            return {b[DW-1:PAD], a[DW-1:PAD]};
        end else if (w32) begin
            return {{WW{1'b0}}, a[DW-1:PAD]};
        end
        return {a, {PX_MOVE_LSB{1'b0}}};
    endfunction

    // bus to register: 32-bit words are left-justified with the low byte cleared
    function automatic dprf_reg_t dprf_unpack(input logic lw, input logic w32,
                                              input logic hi, input dprf_bus_t d);
        if (lw || w32) begin
            return {(hi ? d[BW-1:WW] : d[WW-1:0]), {PAD{1'b0}}};
        end
        return d[BW-1:PX_MOVE_LSB];
    endfunction
endpackage

/* File: pkg/dprf_bank_if.sv */
`timescale 1ns/1ps
interface dprf_bank_if;
    logic                alt;
    logic [7:0]          wr_en;
    dprf_pkg::dprf_idx_t wr_idx  [dprf_pkg::NSRC];
    dprf_pkg::dprf_reg_t wr_data [dprf_pkg::NSRC];
    dprf_pkg::dprf_idx_t rd_idx  [dprf_pkg::NRD];
    dprf_pkg::dprf_reg_t rd_data [dprf_pkg::NRD];

    modport owner (output alt, output wr_en, output wr_idx, output wr_data,
                   output rd_idx, input rd_data);
    modport bank  (input alt, input wr_en, input wr_idx, input wr_data,
                   input rd_idx, output rd_data);
endinterface

/* File: src/dprf_bank.sv */
`timescale 1ns/1ps
module dprf_bank (
    // clock and reset
    input wire logic  clk,
    input wire logic  rst_n,
    // element side
    dprf_bank_if.bank bif
);
    // one storage per index: fixed and float views share it
    dprf_pkg::dprf_reg_t mem_r [dprf_pkg::NSET][dprf_pkg::NREG];

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int s = 0; s < dprf_pkg::NSET; s++) begin
                for (int i = 0; i < dprf_pkg::NREG; i++) begin
                    mem_r[s][i] <= dprf_pkg::REG_RST;
                end
            end
        end else begin
            // lowest precedence first, so the highest source lands last
            for (int k = dprf_pkg::NSRC - 1; k >= 0; k--) begin
                if (bif.wr_en[k]) begin
                    mem_r[bif.alt][bif.wr_idx[k]] <= bif.wr_data[k];
                end
            end
        end
    end

    // the inactive set is neither read nor written
    always_comb begin
        for (int k = 0; k < dprf_pkg::NRD; k++) begin
            bif.rd_data[k] = mem_r[bif.alt][bif.rd_idx[k]];
        end
    end
endmodule

/* File: verification/dprf_cu_model.sv */
`timescale 1ns/1ps
module dprf_cu_model (
    // requests from the bench
    input  wire logic [2:0]          go,
    input  wire dprf_pkg::dprf_idx_t idx,
    input  wire dprf_pkg::dprf_reg_t a_x,
    input  wire dprf_pkg::dprf_reg_t a_y,
    // result ports
    output logic                     alu_wr,
    output dprf_pkg::dprf_idx_t      alu_idx,
    output dprf_pkg::dprf_reg_t      alu_res_x,
    output dprf_pkg::dprf_reg_t      alu_res_y,
    output logic                     mul_wr,
    output dprf_pkg::dprf_idx_t      mul_idx,
    output dprf_pkg::dprf_reg_t      mul_res_x,
    output dprf_pkg::dprf_reg_t      mul_res_y,
    output logic                     shf_wr,
    output dprf_pkg::dprf_idx_t      shf_idx,
    output dprf_pkg::dprf_reg_t      shf_res_x,
    output dprf_pkg::dprf_reg_t      shf_res_y
);
    assign alu_wr = go[0];
    assign mul_wr = go[1];
    assign shf_wr = go[2];
    // idle units show a scrambled index and inverted lanes, never a stale result
    assign alu_idx = go[0] ? idx : ~idx;
    assign mul_idx = go[1] ? idx : ~idx;
    assign shf_idx = go[2] ? idx : ~idx;
    // both lanes run the same operation on their own operand
    assign alu_res_x = go[0] ? a_x + 40'h00_0000_0001 : ~a_x;
    assign alu_res_y = go[0] ? a_y + 40'h00_0000_0001 : ~a_y;
    assign mul_res_x = go[1] ? a_x << 1 : ~a_x;
    assign mul_res_y = go[1] ? a_y << 1 : ~a_y;
    assign shf_res_x = go[2] ? a_x >> 1 : ~a_x;
    assign shf_res_y = go[2] ? a_y >> 1 : ~a_y;
endmodule

/* File: verification/dprf_top_tb.sv */
`timescale 1ns/1ps
module dprf_top_tb;
    logic                clk;
    logic                rst_n;
    logic                simd_en, alt_wr, alt_val, alt_sel_q;
    logic                rq [2], wq [2], el [2], lw [2], w3 [2], rv [2];
    dprf_pkg::dprf_idx_t ix [2];
    dprf_pkg::dprf_bus_t wx [2], wy [2], rx [2], ry [2];
    logic                px_lo_wr, px_hi_wr, px_to_reg;
    logic [31:0]         px_wdata;
    dprf_pkg::dprf_idx_t px_idx, cu_idx, alu_idx, mul_idx, shf_idx;
    dprf_pkg::dprf_bus_t px_q;
    logic [2:0]          cu_go;
    logic                alu_wr, mul_wr, shf_wr;
    dprf_pkg::dprf_reg_t cu_ax, cu_ay, alu_res_x, alu_res_y;
    dprf_pkg::dprf_reg_t mul_res_x, mul_res_y, shf_res_x, shf_res_y;
    int                  err_total, n_tests;

    dprf_top i_dut (.clk(clk), .rst_n(rst_n), .simd_en(simd_en), .alt_wr(alt_wr),
        .alt_val(alt_val), .alt_sel_q(alt_sel_q),
        .dm_req(rq[0]), .dm_wr(wq[0]), .dm_elem(el[0]), .dm_lw(lw[0]), .dm_w32(w3[0]),
        .dm_idx(ix[0]), .dm_wdata_x(wx[0]), .dm_wdata_y(wy[0]), .dm_rvalid(rv[0]),
        .dm_rdata_x(rx[0]), .dm_rdata_y(ry[0]),
        .pm_req(rq[1]), .pm_wr(wq[1]), .pm_elem(el[1]), .pm_lw(lw[1]), .pm_w32(w3[1]),
        .pm_idx(ix[1]), .pm_wdata_x(wx[1]), .pm_wdata_y(wy[1]), .pm_rvalid(rv[1]),
        .pm_rdata_x(rx[1]), .pm_rdata_y(ry[1]),
        .px_lo_wr(px_lo_wr), .px_hi_wr(px_hi_wr), .px_wdata(px_wdata),
        .px_to_reg(px_to_reg), .px_idx(px_idx), .px_q(px_q),
        .alu_wr(alu_wr), .alu_idx(alu_idx), .alu_res_x(alu_res_x), .alu_res_y(alu_res_y),
        .mul_wr(mul_wr), .mul_idx(mul_idx), .mul_res_x(mul_res_x), .mul_res_y(mul_res_y),
        .shf_wr(shf_wr), .shf_idx(shf_idx), .shf_res_x(shf_res_x), .shf_res_y(shf_res_y));

    dprf_cu_model i_cu (.go(cu_go), .idx(cu_idx), .a_x(cu_ax), .a_y(cu_ay),
        .alu_wr(alu_wr), .alu_idx(alu_idx), .alu_res_x(alu_res_x), .alu_res_y(alu_res_y),
        .mul_wr(mul_wr), .mul_idx(mul_idx), .mul_res_x(mul_res_x), .mul_res_y(mul_res_y),
        .shf_wr(shf_wr), .shf_idx(shf_idx), .shf_res_x(shf_res_x), .shf_res_y(shf_res_y));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
        n_tests++;
        if (g !== e) begin
            $display("unexpected %s expected %h seen %h", nm, e, g);
            err_total++;
        end
    endtask

    // p selects the bus: 0 data memory, 1 program memory
    task automatic set(input int p, input logic r, input logic w, input logic e,
                       input logic l, input logic s, input logic [3:0] i,
                       input logic [63:0] dx, input logic [63:0] dy);
        rq[p] = r;
        wq[p] = w;
        el[p] = e;
        lw[p] = l;
        w3[p] = s;
        ix[p] = i;
        wx[p] = dx;
        wy[p] = dy;
    endtask

    task automatic wr(input int p, input logic e, input logic l, input logic s,
                      input logic [3:0] i, input logic [63:0] dx, input logic [63:0] dy);
        set(p, 1'b1, 1'b1, e, l, s, i, dx, dy);
        @(negedge clk);
        rq[p] = 1'b0;
        @(negedge clk);
    endtask

    task automatic rd(input int p, input logic e, input logic l, input logic s,
                      input logic [3:0] i, input logic [63:0] ex, input logic [63:0] ey);
        set(p, 1'b1, 1'b0, e, l, s, i, 64'h0, 64'h0);
        @(negedge clk);
        chk("rvalid", 64'h1, {63'h0, rv[p]});
        chk("rdata_x", ex, rx[p]);
        chk("rdata_y", ey, ry[p]);
        rq[p] = 1'b0;
        @(negedge clk);
    endtask

    task automatic t_reset();
        chk("alt_sel_q", 64'h0, {63'h0, alt_sel_q});
        chk("px_q", 64'h0, px_q);
        rd(0, 1'b0, 1'b0, 1'b0, 4'hF, 64'h0, 64'h0);
        @(negedge clk);
        chk("dm_rvalid", 64'h0, {63'h0, rv[0]});
        chk("dm_rdata_x", 64'h0, rx[0]);
        $display("test reset done");
    endtask

    task automatic t_w32();
        wr(1, 1'b0, 1'b0, 1'b1, 4'h3, 64'hFFFF_FFFF_1234_5678, 64'h0);
        wr(0, 1'b0, 1'b0, 1'b0, 4'h9, 64'hABCD_EF01_23FF_FFFF, 64'h0);
        set(0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 4'h3, 64'h0, 64'h0);
        set(1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 4'h3, 64'h0, 64'h0);
        @(negedge clk);
        chk("dm_rdata_x", 64'h1234_5678_0000_0000, rx[0]);
        chk("pm_rdata_x", 64'h0000_0000_1234_5678, rx[1]);
        chk("both_rvalid", 64'h3, {62'h0, rv[1], rv[0]});
        rq[0] = 1'b0;
        rq[1] = 1'b0;
        @(negedge clk);
        rd(1, 1'b0, 1'b0, 1'b1, 4'h9, 64'h0000_0000_ABCD_EF01, 64'h0);
        $display("test word32 done");
    endtask

    task automatic t_lw();
        wr(0, 1'b0, 1'b1, 1'b0, 4'h5, 64'hAAAA_BBBB_CCCC_DDDD, 64'h0);
        rd(1, 1'b0, 1'b0, 1'b1, 4'h4, 64'h0000_0000_CCCC_DDDD, 64'h0);
        rd(1, 1'b0, 1'b0, 1'b1, 4'h5, 64'h0000_0000_AAAA_BBBB, 64'h0);
        rd(1, 1'b0, 1'b1, 1'b0, 4'h4, 64'hAAAA_BBBB_CCCC_DDDD, 64'h0);
        $display("test long word done");
    endtask

    task automatic alu_op(input logic [3:0] i, input logic [39:0] ax, input logic [39:0] ay);
        cu_go = 3'b001;
        cu_idx = i;
        cu_ax = ax;
        cu_ay = ay;
        @(negedge clk);
        cu_go = 3'b000;
    endtask

    task automatic t_modes();
        simd_en = 1'b0;
        wr(0, 1'b1, 1'b0, 1'b1, 4'h2, 64'h0, 64'h0000_0000_BBBB_BBBB);
        rd(0, 1'b1, 1'b0, 1'b1, 4'h2, 64'h0, 64'h0000_0000_BBBB_BBBB);
        alu_op(4'h2, 40'h00_0000_0001, 40'h00_0000_0002);
        rd(0, 1'b0, 1'b0, 1'b0, 4'h2, 64'h0000_0000_0200_0000, 64'h0);
        rd(0, 1'b1, 1'b0, 1'b0, 4'h2, 64'h0, 64'hBBBB_BBBB_0000_0000);
        simd_en = 1'b1;
        alu_op(4'h2, 40'h00_0000_0004, 40'h00_0000_0008);
        rd(1, 1'b0, 1'b0, 1'b0, 4'h2, 64'h0000_0000_0500_0000, 64'h0000_0000_0900_0000);
        wr(1, 1'b0, 1'b0, 1'b1, 4'hC, 64'h0000_0000_1111_1111, 64'h0000_0000_2222_2222);
        rd(0, 1'b0, 1'b0, 1'b1, 4'hC, 64'h0000_0000_1111_1111, 64'h0000_0000_2222_2222);
        simd_en = 1'b0;
        $display("test element modes done");
    endtask

    task automatic t_px();
        px_wdata = 32'h5555_5555;
        px_hi_wr = 1'b1;
        @(negedge clk);
        px_hi_wr = 1'b0;
        px_wdata = 32'h9A00_0000;
        px_lo_wr = 1'b1;
        @(negedge clk);
        chk("px_q", 64'h5555_5555_9A00_0000, px_q);
        px_wdata = 32'h1200_0000;
        @(negedge clk);
        px_lo_wr = 1'b0;
        chk("px_q", 64'h5555_5555_1200_0000, px_q);
        px_idx = 4'h7;
        px_to_reg = 1'b1;
        @(negedge clk);
        px_to_reg = 1'b0;
        rd(0, 1'b0, 1'b0, 1'b0, 4'h7, 64'h5555_5555_1200_0000, 64'h0);
        $display("test exchange done");
    endtask

    task automatic t_prec();
        logic [39:0] ex [6];
        ex = '{40'h11_1111_1111, 40'h55_5555_5512, 40'h33_3333_3333,
               40'h10_0000_0001, 40'h20_0000_0000, 40'h08_0000_0000};
        for (int k = 0; k < 6; k++) begin
            set(0, k == 0, 1'b1, 1'b0, 1'b0, 1'b0, 4'h6, {ex[0], 24'h00_0000}, 64'h0);
            set(1, k <= 2, 1'b1, 1'b0, 1'b0, 1'b0, 4'h6, {ex[2], 24'h00_0000}, 64'h0);
            px_to_reg = (k <= 1);
            px_idx = 4'h6;
            cu_go = {k <= 5, k <= 4, k <= 3};
            cu_idx = 4'h6;
            cu_ax = 40'h10_0000_0000;
            @(negedge clk);
            rq[0] = 1'b0;
            rq[1] = 1'b0;
            px_to_reg = 1'b0;
            cu_go = 3'b000;
            @(negedge clk);
            rd(0, 1'b0, 1'b0, 1'b0, 4'h6, {ex[k], 24'h00_0000}, 64'h0);
        end
        $display("test precedence done");
    endtask

    task automatic alt_set(input logic v);
        alt_wr = 1'b1;
        alt_val = v;
        @(negedge clk);
        alt_wr = 1'b0;
        chk("alt_sel_q", {63'h0, v}, {63'h0, alt_sel_q});
    endtask

    task automatic t_alt();
        wr(0, 1'b0, 1'b0, 1'b1, 4'h1, 64'h0000_0000_AAAA_AAAA, 64'h0);
        alt_set(1'b1);
        rd(0, 1'b0, 1'b0, 1'b1, 4'h1, 64'h0, 64'h0);
        wr(0, 1'b0, 1'b0, 1'b1, 4'h1, 64'h0000_0000_5555_5555, 64'h0);
        rd(1, 1'b0, 1'b0, 1'b1, 4'h1, 64'h0000_0000_5555_5555, 64'h0);
        alt_set(1'b0);
        rd(1, 1'b0, 1'b0, 1'b1, 4'h1, 64'h0000_0000_AAAA_AAAA, 64'h0);
        $display("test alternate set done");
    endtask

    initial begin
        err_total = 0;
        n_tests = 0;
        rst_n = 1'b0;
        {simd_en, alt_wr, alt_val, px_lo_wr, px_hi_wr, px_to_reg} = 6'h00;
        px_wdata = 32'h0000_0000;
        px_idx = 4'h0;
        cu_go = 3'b000;
        cu_idx = 4'h0;
        cu_ax = 40'h00_0000_0000;
        cu_ay = 40'h00_0000_0000;
        for (int p = 0; p < 2; p++) begin
            set(p, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 4'h0, 64'h0, 64'h0);
        end
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        repeat (3) @(negedge clk);
        t_reset();
        t_w32();
        t_lw();
        t_modes();
        t_px();
        t_prec();
        t_alt();
        complete_run();
    end

    // tests need well under 200 cycles
    initial begin
        #20000;
        err_total++;
        complete_run();
    end
endmodule
